// *** hw/csr_pkg.sv ***
// csr_pkg: file addresses, reset values and field layout of the core register bank
// assumes: consumed by csr_core_special_register_bank and its leaf module
package csr_pkg;
  localparam logic [4:0] CSR_ADDR_INDIRECT = 5'h00;
  localparam logic [4:0] CSR_ADDR_TIMER = 5'h01;
  localparam logic [4:0] CSR_ADDR_PC_LOW = 5'h02;
  localparam logic [4:0] CSR_ADDR_FLAGS = 5'h03;
  localparam logic [4:0] CSR_ADDR_POINTER = 5'h04;
  localparam logic [4:0] CSR_ADDR_PORT_A = 5'h05;
  localparam logic [4:0] CSR_ADDR_PORT_B = 5'h06;
  localparam logic [4:0] CSR_ADDR_PORT_C = 5'h07;
  localparam logic [7:0] CSR_RST_PC_LOW = 8'hFF;
  localparam logic [7:0] CSR_RST_DIR = 8'hFF;
  localparam logic [5:0] CSR_RST_CFG = 6'h3F;
  localparam logic [7:0] CSR_RST_FLAGS = 8'h18;
  localparam logic [7:0] CSR_RST_PTR_BIG = 8'h80;
  localparam logic [7:0] CSR_RST_PTR_SMALL = 8'hE0;
  localparam logic [7:0] CSR_PTR_SMALL_MASK = 8'hE0;
  localparam logic [7:0] CSR_PORT_A_MASK = 8'h0F;
  localparam logic [7:0] CSR_FLAGS_WMASK = 8'hE7;
  localparam int CSR_FLAG_TIMEOUT = 4;
  localparam int CSR_FLAG_POWERDOWN = 3;
  localparam logic [1:0] CSR_DIR_SEL_A = 2'h1;
  localparam logic [1:0] CSR_DIR_SEL_B = 2'h2;
  localparam logic [1:0] CSR_DIR_SEL_C = 2'h3;
endpackage : csr_pkg

// *** hw/csr_byte_reg.sv ***
// csr_byte_reg: one file register with mask-limited write and load on reset pulse
// assumes: clocked by the core clock, reset already synchronised
`timescale 1ns/100ps
`default_nettype none
module csr_byte_reg
  import csr_pkg::*;
#(
  parameter int WIDTH = 8,
  parameter logic [WIDTH-1:0] RST_VAL = '0,
  parameter logic [WIDTH-1:0] IMPL_MASK = '1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic soft_rst,
  input wire logic [WIDTH-1:0] soft_set,
  input wire logic [WIDTH-1:0] soft_keep,
  input wire logic wr_en,
  input wire logic [WIDTH-1:0] wr_data,
  output logic [WIDTH-1:0] value
);
  logic [WIDTH-1:0] data_reg;
  logic [WIDTH-1:0] data_next;

  // a zero-width register would leave the value port without bits
  if (WIDTH < 1) begin : g_width_check
    $error("csr_byte_reg: WIDTH must be at least 1");
  end

  always_comb begin
    data_next = data_reg;
    if (soft_rst) begin
      data_next = (data_reg & soft_keep) | soft_set;
    end else if (wr_en) begin
      data_next = wr_data & IMPL_MASK;
    end
  end

  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      data_reg <= RST_VAL & IMPL_MASK;
    end else begin
      data_reg <= data_next;
    end
  end

  assign value = data_reg;
endmodule : csr_byte_reg
`default_nettype wire

// *** hw/csr_core_special_register_bank.sv ***
// csr_core_special_register_bank: core special registers at file 00h..07h plus
// pin direction and timer/prescaler configuration, which have no file address.
// assumes: the processor core drives one access per clock, synchronous to clk;
// data memory beyond 07h lives outside and is reached through mem_* ports.
// What this block does
// RULE1: pointer at 04h addresses data memory; top bit one after power-on.
// RULE2: small-memory parts: pointer top three bits one on any reset, rest kept on warm reset, zero after power-on.
// RULE3: low program counter byte at 02h resets to ones; upper bits unreachable.
// RULE4: without third port, 07h is a plain general-purpose register.
// RULE5: unimplemented bits read zero; port A at 05h has only bits 3..0.
// RULE6: 00h reads and writes the data-memory location named by the pointer.
// RULE7: configuration-load instruction copies working register into 6-bit config.
// RULE8: every reset sets all six configuration bits.
`timescale 1ns/100ps
`default_nettype none
module csr_core_special_register_bank
  import csr_pkg::*;
#(
  parameter bit SMALL_MEMORY = 1'b0,
  parameter bit HAS_PORT_C = 1'b1
) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_wdt_reset,
  input wire logic wdt_reset_cause,
  input wire logic file_rd,
  input wire logic file_wr,
  input wire logic [4:0] file_addr,
  input wire logic [7:0] file_wdata,
  output logic [7:0] file_rdata,
  output logic file_hit,
  output logic mem_rd,
  output logic mem_wr,
  output logic [7:0] mem_addr,
  output logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] work_reg,
  input wire logic cfg_load,
  input wire logic dir_load,
  input wire logic [1:0] dir_sel,
  input wire logic pc_load,
  input wire logic [7:0] pc_low_in,
  input wire logic timer_load,
  input wire logic [7:0] timer_in,
  input wire logic flags_load,
  input wire logic [7:0] flags_in,
  input wire logic [7:0] port_a_in,
  input wire logic [7:0] port_b_in,
  input wire logic [7:0] port_c_in,
  input wire logic sleep_enter,
  input wire logic wdt_clear,
  output logic [7:0] pc_low,
  output logic [7:0] timer_count,
  output logic [7:0] flags,
  output logic [7:0] indirect_pointer,
  output logic [7:0] port_a_out,
  output logic [7:0] port_b_out,
  output logic [7:0] port_c_out,
  output logic [7:0] dir_a,
  output logic [7:0] dir_b,
  output logic [7:0] dir_c,
  output logic [5:0] timer_prescaler_config
);
  logic rst_sync1_reg;
  logic rst_sync2_reg;
  logic srst_n;

  // release of the asynchronous reset is brought onto the clock
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rst_sync1_reg <= 1'b0;
      rst_sync2_reg <= 1'b0;
    end else begin
      rst_sync1_reg <= 1'b1;
      rst_sync2_reg <= rst_sync1_reg;
    end
  end
  assign srst_n = rst_sync2_reg;

  logic wr_ind, wr_tmr, wr_pc_low, wr_flg, wr_ptr, wr_pa, wr_pb, wr_pc;
  assign wr_ind = file_wr && (file_addr == CSR_ADDR_INDIRECT);
  assign wr_tmr = file_wr && (file_addr == CSR_ADDR_TIMER);
  assign wr_pc_low = file_wr && (file_addr == CSR_ADDR_PC_LOW);
  assign wr_flg = file_wr && (file_addr == CSR_ADDR_FLAGS);
  assign wr_ptr = file_wr && (file_addr == CSR_ADDR_POINTER);
  assign wr_pa = file_wr && (file_addr == CSR_ADDR_PORT_A);
  assign wr_pb = file_wr && (file_addr == CSR_ADDR_PORT_B);
  assign wr_pc = file_wr && (file_addr == CSR_ADDR_PORT_C);

  // register of the larger part resets to the power-on value only
  localparam logic [7:0] PTR_RST = SMALL_MEMORY ? CSR_RST_PTR_SMALL : CSR_RST_PTR_BIG;
  localparam logic [7:0] PTR_KEEP = SMALL_MEMORY ? ~CSR_PTR_SMALL_MASK : 8'hFF;
  localparam logic [7:0] PTR_SET = SMALL_MEMORY ? CSR_PTR_SMALL_MASK : 8'h00;

  // pointer; warm reset on the small part forces top bits, keeps the rest
  csr_byte_reg #(.WIDTH(8), .RST_VAL(PTR_RST)) u_pointer (
    .clk(clk), .rst_n(srst_n), .soft_rst(ext_wdt_reset), // [RULE1] [RULE2]
    .soft_set(PTR_SET), .soft_keep(PTR_KEEP),
    .wr_en(wr_ptr), .wr_data(file_wdata), .value(indirect_pointer)
  );

  // only the low byte exists here; the upper bits stay inside the core
  csr_byte_reg #(.WIDTH(8), .RST_VAL(CSR_RST_PC_LOW)) u_pc_low (
    .clk(clk), .rst_n(srst_n), .soft_rst(ext_wdt_reset), // [RULE3]
    .soft_set(CSR_RST_PC_LOW), .soft_keep(8'h00),
    .wr_en(wr_pc_low || pc_load), .wr_data(wr_pc_low ? file_wdata : pc_low_in),
    .value(pc_low)
  );

  csr_byte_reg #(.WIDTH(8)) u_timer (
    .clk(clk), .rst_n(srst_n), .soft_rst(1'b0),
    .soft_set(8'h00), .soft_keep(8'hFF),
    .wr_en(wr_tmr || timer_load), .wr_data(wr_tmr ? file_wdata : timer_in),
    .value(timer_count)
  );

  // port output latches; port A keeps only its four pins
  csr_byte_reg #(.WIDTH(8), .IMPL_MASK(CSR_PORT_A_MASK)) u_port_a (
    .clk(clk), .rst_n(srst_n), .soft_rst(1'b0),
    .soft_set(8'h00), .soft_keep(8'hFF),
    .wr_en(wr_pa), .wr_data(file_wdata), .value(port_a_out) // [RULE5]
  );

  csr_byte_reg #(.WIDTH(8)) u_port_b (
    .clk(clk), .rst_n(srst_n), .soft_rst(1'b0),
    .soft_set(8'h00), .soft_keep(8'hFF),
    .wr_en(wr_pb), .wr_data(file_wdata), .value(port_b_out)
  );

  // on parts without the third port this same latch is plain storage
  csr_byte_reg #(.WIDTH(8)) u_port_c (
    .clk(clk), .rst_n(srst_n), .soft_rst(1'b0),
    .soft_set(8'h00), .soft_keep(8'hFF),
    .wr_en(wr_pc), .wr_data(file_wdata), .value(port_c_out) // [RULE4]
  );

  // timer/prescaler configuration, write-only, loaded from the working register
  csr_byte_reg #(.WIDTH(6), .RST_VAL(CSR_RST_CFG)) u_cfg (
    .clk(clk), .rst_n(srst_n), .soft_rst(ext_wdt_reset), // [RULE8]
    .soft_set(CSR_RST_CFG), .soft_keep(6'h00),
    .wr_en(cfg_load), .wr_data(work_reg[5:0]), // [RULE7]
    .value(timer_prescaler_config)
  );

  // pin direction latches, all inputs after any reset
  logic [7:0] dir_a_reg, dir_a_next, dir_b_reg, dir_b_next, dir_c_reg, dir_c_next;

  always_comb begin
    dir_a_next = dir_a_reg;
    dir_b_next = dir_b_reg;
    dir_c_next = dir_c_reg;
    if (ext_wdt_reset) begin
      dir_a_next = CSR_RST_DIR;
      dir_b_next = CSR_RST_DIR;
      dir_c_next = CSR_RST_DIR;
    end else if (dir_load) begin
      if (dir_sel == CSR_DIR_SEL_A) begin
        dir_a_next = work_reg;
      end
      if (dir_sel == CSR_DIR_SEL_B) begin
        dir_b_next = work_reg;
      end
      if (dir_sel == CSR_DIR_SEL_C && HAS_PORT_C) begin
        dir_c_next = work_reg;
      end
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      dir_a_reg <= CSR_RST_DIR;
      dir_b_reg <= CSR_RST_DIR;
      dir_c_reg <= CSR_RST_DIR;
    end else begin
      dir_a_reg <= dir_a_next;
      dir_b_reg <= dir_b_next;
      dir_c_reg <= dir_c_next;
    end
  end

  assign dir_a = dir_a_reg & CSR_PORT_A_MASK;
  assign dir_b = dir_b_reg;
  assign dir_c = dir_c_reg;

  // processor flags: timeout/powerdown are read-only to the file path
  logic [7:0] flags_reg, flags_next;

  always_comb begin
    flags_next = flags_reg;
    if (flags_load) begin
      flags_next = flags_in;
    end
    if (wr_flg) begin
      flags_next = (flags_next & ~CSR_FLAGS_WMASK) | (file_wdata & CSR_FLAGS_WMASK);
    end
    if (ext_wdt_reset) begin
      flags_next[7:5] = 3'h0;
      flags_next[CSR_FLAG_TIMEOUT] = ~wdt_reset_cause;
    end
    if (wdt_clear) begin
      flags_next[CSR_FLAG_TIMEOUT] = 1'b1;
      flags_next[CSR_FLAG_POWERDOWN] = 1'b1;
    end
    if (sleep_enter) begin
      flags_next[CSR_FLAG_TIMEOUT] = 1'b1;
      flags_next[CSR_FLAG_POWERDOWN] = 1'b0;
    end
  end

  always_ff @(posedge clk or negedge srst_n) begin
    if (!srst_n) begin
      flags_reg <= CSR_RST_FLAGS;
    end else begin
      flags_reg <= flags_next;
    end
  end
  assign flags = flags_reg;

  // indirect access goes straight through to data memory
  assign mem_addr = indirect_pointer; // [RULE6]
  assign mem_rd = file_rd && (file_addr == CSR_ADDR_INDIRECT); // [RULE6]
  assign mem_wr = wr_ind; // [RULE6]
  assign mem_wdata = file_wdata;

  // read mux; port pins read live, unimplemented bits read zero
  logic [7:0] rdata;
  always_comb begin
    rdata = 8'h00;
    file_hit = 1'b1;
    unique case (file_addr)
      CSR_ADDR_INDIRECT: rdata = mem_rdata; // [RULE6]
      CSR_ADDR_TIMER: rdata = timer_count;
      CSR_ADDR_PC_LOW: rdata = pc_low; // [RULE3]
      CSR_ADDR_FLAGS: rdata = flags_reg;
      CSR_ADDR_POINTER: rdata = indirect_pointer;
      CSR_ADDR_PORT_A: rdata = port_a_in & CSR_PORT_A_MASK; // [RULE5]
      CSR_ADDR_PORT_B: rdata = port_b_in;
      CSR_ADDR_PORT_C: rdata = HAS_PORT_C ? port_c_in : port_c_out; // [RULE4]
      default: begin
        rdata = 8'h00;
        file_hit = 1'b0;
      end
    endcase
  end
  assign file_rdata = file_rd ? rdata : 8'h00;
endmodule : csr_core_special_register_bank
`default_nettype wire

// *** tb/csr_mem_model.sv ***
// csr_mem_model: data memory reached through the bank's indirect port
// assumes: mem_* strobes from the bank, synchronous to the core clock
`timescale 1ns/100ps
`default_nettype none
module csr_mem_model (
  input wire logic clk,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  output logic [7:0] mem_rdata
);
  logic [7:0] mem_q [256];
  logic [7:0] last_reg = 8'h00;
  // released bus shows the inverse, so stale data never passes
  assign mem_rdata = mem_rd ? mem_q[mem_addr] : ~last_reg;
  initial begin
    for (int i = 0; i < 256; i++) mem_q[i] = 8'(i) ^ 8'h5A;
  end
  always @(posedge clk) begin
    if (mem_wr) mem_q[mem_addr] <= mem_wdata;
    if (mem_rd) last_reg <= mem_q[mem_addr];
  end
endmodule : csr_mem_model
`default_nettype wire

// *** tb/csr_chk.sv ***
// csr_chk: port-level checks of the core register bank
// assumes: bound into every bank instance; one clock domain
`timescale 1ns/100ps
`default_nettype none
module csr_chk #(parameter bit SMALL_MEMORY = 1'b0) (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic ext_wdt_reset,
  input wire logic file_rd,
  input wire logic file_wr,
  input wire logic [4:0] file_addr,
  input wire logic [7:0] file_wdata,
  input wire logic [7:0] file_rdata,
  input wire logic file_hit,
  input wire logic mem_rd,
  input wire logic mem_wr,
  input wire logic [7:0] mem_addr,
  input wire logic [7:0] mem_wdata,
  input wire logic [7:0] mem_rdata,
  input wire logic [7:0] work_reg,
  input wire logic cfg_load,
  input wire logic pc_load,
  input wire logic [7:0] pc_low,
  input wire logic [7:0] indirect_pointer,
  input wire logic [7:0] port_a_out,
  input wire logic [7:0] dir_a,
  input wire logic [5:0] timer_prescaler_config
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rst_n);
  property p_pa_hi; port_a_out[7:4] == 4'h0 && dir_a[7:4] == 4'h0; endproperty
  a_pa_hi: assert property (p_pa_hi) else $error("port a upper bits set");
  property p_unmap; file_rd && file_addr > 5'h07 |-> file_rdata == 8'h00 && !file_hit; endproperty
  a_unmap: assert property (p_unmap) else $error("unmapped read not zero");
  property p_ind_rd; file_rd && file_addr == 5'h00 |-> mem_rd && mem_addr == indirect_pointer
    && file_rdata == mem_rdata; endproperty
  a_ind_rd: assert property (p_ind_rd) else $error("indirect read wrong");
  property p_ind_wr; file_wr && file_addr == 5'h00 |-> mem_wr && mem_wdata == file_wdata;
  endproperty
  a_ind_wr: assert property (p_ind_wr) else $error("indirect write wrong");
  property p_ptr; file_wr && file_addr == 5'h04 && !ext_wdt_reset |=>
    indirect_pointer == $past(file_wdata); endproperty
  a_ptr: assert property (p_ptr) else $error("pointer write lost");
  property p_cfg; cfg_load && !ext_wdt_reset |=>
    timer_prescaler_config == $past(work_reg[5:0]); endproperty
  a_cfg: assert property (p_cfg) else $error("config load wrong");
  property p_wrst; ext_wdt_reset && !cfg_load && !pc_load && !file_wr |=>
    timer_prescaler_config == 6'h3F && pc_low == 8'hFF; endproperty
  a_wrst: assert property (p_wrst) else $error("warm reset values wrong");
  property p_pkeep; ext_wdt_reset && !file_wr |=> indirect_pointer ==
    ($past(indirect_pointer) | (SMALL_MEMORY ? 8'hE0 : 8'h00)); endproperty
  a_pkeep: assert property (p_pkeep) else $error("pointer warm reset wrong");
  property p_pc_low; file_rd && file_addr == 5'h02 |-> file_rdata == pc_low; endproperty
  a_pc_low: assert property (p_pc_low) else $error("pc low read wrong");
endmodule : csr_chk
bind csr_core_special_register_bank csr_chk #(.SMALL_MEMORY(SMALL_MEMORY)) csr_chk_i (.*);
`default_nettype wire

// *** tb/csr_core_special_register_bank_test.sv ***
// csr_core_special_register_bank_test: random core traffic against a bench model
// assumes: small-memory variant without third port; data memory from csr_mem_model
`timescale 1ns/100ps
`default_nettype none
module csr_core_special_register_bank_test;
  import csr_pkg::*;
  logic clk = 1'b0, rst_n = 1'b0, ext_wdt_reset = 1'b0, wdt_reset_cause = 1'b0;
  logic file_rd = 1'b0, file_wr = 1'b0, cfg_load = 1'b0, pc_load = 1'b0, mem_rd, mem_wr;
  logic dir_load = 1'b0, timer_load = 1'b0, flags_load = 1'b0;
  logic [4:0] file_addr = 5'h00, a;
  logic [7:0] file_wdata = 8'h00, work_reg = 8'h00, pc_low_in = 8'h00, pins = 8'h00;
  logic [7:0] file_rdata, mem_addr, mem_wdata, mem_rdata, pc_low, indirect_pointer, dir_b;
  logic [7:0] flags, timer_count, port_a_out;
  logic [5:0] timer_prescaler_config;
  logic [7:0] mm [256], ptr = 8'hE0, cfg = 8'h3F, pcv = 8'hFF, d;
  logic [7:0] dirb = 8'hFF, tmr = 8'h00, flg = CSR_RST_FLAGS;
  integer seed = 53233, miscompares = 0, cmp_count = 0, cycles = 0, op;
  csr_core_special_register_bank #(.SMALL_MEMORY(1'b1), .HAS_PORT_C(1'b0))
    csr_core_special_register_bank_i (.clk, .rst_n, .ext_wdt_reset, .wdt_reset_cause,
    .file_rd, .file_wr, .file_addr, .file_wdata, .file_rdata, .file_hit(), .mem_rd, .mem_wr,
    .mem_addr, .mem_wdata, .mem_rdata, .work_reg, .cfg_load, .dir_load,
    .dir_sel(pins[1:0]), .pc_load, .pc_low_in, .timer_load, .timer_in(pins),
    .flags_load, .flags_in(pins), .port_a_in(pins), .port_b_in(pins), .port_c_in(pins),
    .sleep_enter(1'b0), .wdt_clear(1'b0), .pc_low, .timer_count, .flags,
    .indirect_pointer, .port_a_out, .port_b_out(), .port_c_out(), .dir_a(), .dir_b,
    .dir_c(), .timer_prescaler_config);
  csr_mem_model csr_mem_model_i (.clk, .mem_rd, .mem_wr, .mem_addr, .mem_wdata, .mem_rdata);
  task automatic final_report;
    if (miscompares == 0 && cmp_count > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      miscompares++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : chk
  // st = {flags, timer, dir, warm reset, config, pc, read, write}; one access per cycle
  task automatic go(input logic [7:0] st, input logic [4:0] ad, input logic [7:0] dv);
    @(posedge clk);
    {flags_load, timer_load, dir_load, ext_wdt_reset, cfg_load, pc_load, file_rd, file_wr} <= st;
    file_addr <= ad;
    file_wdata <= dv;
    work_reg <= dv;
    pc_low_in <= dv;
    pins <= $random(seed);
    wdt_reset_cause <= $random(seed);
    @(negedge clk);
  endtask : go
  task automatic regs;
    go(8'h00, 5'h00, 8'h00);
    chk("pointer", indirect_pointer, ptr);
    chk("config", {2'b00, timer_prescaler_config}, cfg);
    chk("direction b", dir_b, dirb);
    chk("timer", timer_count, tmr);
    chk("flags", flags, flg);
    go(8'h02, 5'h02, 8'h00);
    chk("pc low", file_rdata, pcv);
  endtask : regs
  initial begin
    forever #50 clk = ~clk;
  end
  always @(posedge clk) begin
    cycles++;
    if (cycles == 2000) begin
      miscompares++;
      final_report;
    end
  end
  initial begin
    for (int i = 0; i < 256; i++) mm[i] = 8'(i) ^ 8'h5A;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk);
    regs;
    chk("direction b", dir_b, 8'hFF);
    for (int i = 0; i < 80; i++) begin
      op = {$random(seed)} % 12;
      d = $random(seed);
      a = $random(seed);
      case (op)
        0: begin go(8'h01, 5'h04, d); ptr = d; end
        1: begin go(8'h01, 5'h00, d); mm[ptr] = d; end
        2: begin go(8'h02, 5'h00, d); chk("indirect", file_rdata, mm[ptr]); end
        3: begin go(8'h08, 5'h00, d); cfg = d & 8'h3F; end
        4: begin
          go(8'h10, 5'h00, d);
          cfg = 8'h3F;
          pcv = 8'hFF;
          ptr = ptr | 8'hE0;
          dirb = 8'hFF;
          flg = {3'b000, ~wdt_reset_cause, flg[3:0]};
        end
        5: begin go(8'h02, a | 5'h08, d); chk("unmapped", file_rdata, 8'h00); end
        6: begin
          go(8'h01, 5'h07, d);
          go(8'h02, 5'h07, d);
          chk("file 07h", file_rdata, d);
        end
        7: begin go(8'h04, 5'h00, d); pcv = d; end
        // direction select comes from the random pin word, so only some loads hit B
        8: begin go(8'h20, 5'h00, d); if (pins[1:0] == 2'h2) dirb = d; end
        9: begin go(8'h40, 5'h00, d); tmr = pins; end
        10: begin go(8'h80, 5'h00, d); flg = pins; end
        default: begin
          go(8'h01, 5'h05, d);
          go(8'h02, 5'h05, d);
          chk("port a pins", file_rdata, pins & 8'h0F);
          chk("port a latch", port_a_out, d & 8'h0F);
        end
      endcase
      regs;
    end
    final_report;
  end
endmodule : csr_core_special_register_bank_test
`default_nettype wire
